// *** hw/bt1ch_defines.svh ***
// Offsets, field positions, reset values and fixed codes of the bridge header.
`ifndef BT1CH_DEFINES_SVH
`define BT1CH_DEFINES_SVH

`define BT1CH_OFS_ID 8'h00
`define BT1CH_OFS_CMD_STS 8'h04
`define BT1CH_OFS_CLASS 8'h08
`define BT1CH_OFS_MISC 8'h0c
`define BT1CH_OFS_BUS 8'h18
`define BT1CH_OFS_IO 8'h1c

// Identity defaults and the revision are arbitrary neutral values.
`define BT1CH_MAKER_ID_RST 16'h1a2b
`define BT1CH_PART_ID_RST 16'h3c4d
`define BT1CH_REVISION 8'h01

`define BT1CH_CMD_IO_EN 0
`define BT1CH_CMD_MEM_EN 1
`define BT1CH_CMD_BM_EN 2
`define BT1CH_CMD_PERR_RESP 6
`define BT1CH_CMD_ERR_REP 8
`define BT1CH_CMD_INTX_DIS 10
`define BT1CH_CMD_RW_MASK 16'h0547

`define BT1CH_STS_INT 19
`define BT1CH_STS_CAP 20
`define BT1CH_STS_MDPE 24
`define BT1CH_STS_STA 27
`define BT1CH_STS_RTA 28
`define BT1CH_STS_RMA 29
`define BT1CH_STS_SSE 30
`define BT1CH_STS_DPE 31

`define BT1CH_BASE_CLASS 8'h06
`define BT1CH_SUB_CLASS 8'h04
`define BT1CH_PROG_IF 8'h00
`define BT1CH_HDR_TYPE 8'h01
`define BT1CH_LAT_TIMER 8'h00
`define BT1CH_IO_32BIT 4'h1
`define BT1CH_BYTE_RST 8'h00
`define BT1CH_NIB_RST 4'h0
`define BT1CH_IO_LOW_ZERO 12'h000
`define BT1CH_IO_LOW_ONES 12'hfff

`endif

// *** hw/bt1ch_pkg.sv ***
// Types shared by the bridge header register bank.
package bt1ch_pkg;

  typedef logic [7:0] bt1ch_byte_t;
  typedef logic [31:0] bt1ch_word_t;
  typedef logic [3:0] bt1ch_be_t;

endpackage : bt1ch_pkg

// *** hw/bt1ch_regs.sv ***
// Type 1 bridge configuration header, offsets 00h to 1Ch, with side outputs.
//
// Notes on behaviour
// - Identity fields read-only; defaults replaceable by management load.
// - Command bit 0 enables primary I/O decode; resets to zero.
// - Command bit 1 enables primary memory decode; resets to zero.
// - Bit 2 clear: no upstream forwarding, requests from below are UR.
// - Command bits 3, 4, 5, 7 and 9 read zero, writes ignored.
// - Command bit 6 enables normal parity error handling.
// - Command bit 8 enables error reporting to the root; resets zero.
// - Command bit 10 masks own INTx only, never forwarded INTx.
// - Status bit 19 always reads zero.
// - Status bit 20 always reads one; capability pointer lives at 34h.
// - Status bit 24 set on primary parity error only if bit 6 set.
// - Status bit 27 set on completer abort sent; resets zero.
// - Status bits 28 and 29 set on received CA and UR completions.
// - Status bit 30 set on error message sent while bit 8 set.
// - Status bit 31 set on poisoned packet received; resets zero.
// - Class code reads 06h, 04h, 00h and is read-only.
// - Cache line size is read-write, unused, resets 00h.
// - Header type reads constant 01h.
// - Primary, secondary, subordinate bus numbers writable, reset 00h.
// - Both latency timers read 00h and ignore writes.
// - I/O base bits 7:4 give address 15:12; low bits zero.
// - I/O limit bits 15:12 give address 15:12; low bits all ones.
// - I/O base and limit indicator nibbles read one.
// - Write one clears a clearable status bit; write zero leaves it.
`timescale 1ns/1ps
`include "bt1ch_defines.svh"

module bt1ch_regs
(
  input wire logic ref_clk,
  input wire logic nrst,
  // Configuration request port.
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [7:0] cfg_addr,
  input wire bt1ch_pkg::bt1ch_be_t cfg_be,
  input wire bt1ch_pkg::bt1ch_word_t cfg_wdata,
  output logic cfg_ack,
  output bt1ch_pkg::bt1ch_word_t cfg_rdata,
  // Identity load from the management port or serial memory.
  input wire logic id_load,
  input wire bt1ch_pkg::bt1ch_word_t id_load_data,
  // Events from the port datapath, one-cycle pulses.
  input wire logic parity_err_evt,
  input wire logic ca_sent_evt,
  input wire logic ca_rcvd_evt,
  input wire logic ur_rcvd_evt,
  input wire logic err_msg_sent_evt,
  input wire logic poison_rcvd_evt,
  // Error message request from the port's own error logic.
  input wire logic err_detect,
  output logic err_msg_send,
  // Own and forwarded interrupt requests.
  input wire logic own_intx_req,
  input wire logic fwd_intx_req,
  output logic own_intx_msg,
  output logic fwd_intx_msg,
  // Upstream request from below.
  input wire logic up_req_valid,
  input wire logic up_req_nonposted,
  output logic up_forward,
  output logic up_unsupported,
  output logic up_ur_cpl,
  // Control levels and windows for the forwarding datapath.
  output logic io_space_en,
  output logic mem_space_en,
  output logic bus_master_en,
  output logic parity_resp_en,
  output logic error_report_enable,
  output bt1ch_pkg::bt1ch_byte_t primary_bus,
  output bt1ch_pkg::bt1ch_byte_t secondary_bus,
  output bt1ch_pkg::bt1ch_byte_t subordinate_bus,
  input wire logic [15:0] io_addr,
  output logic io_in_window,
  output logic io_primary_hit
);
  import bt1ch_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Dword offsets as byte-wide constants, so that only their top six bits
  // take part in the decode and no comparison mixes widths.

  localparam bt1ch_byte_t ofs_id = `BT1CH_OFS_ID;
  localparam bt1ch_byte_t ofs_cmd_sts = `BT1CH_OFS_CMD_STS;
  localparam bt1ch_byte_t ofs_class = `BT1CH_OFS_CLASS;
  localparam bt1ch_byte_t ofs_misc = `BT1CH_OFS_MISC;
  localparam bt1ch_byte_t ofs_bus = `BT1CH_OFS_BUS;
  localparam bt1ch_byte_t ofs_io = `BT1CH_OFS_IO;
  // Writable command bits; legacy and reserved bits never reach a flop.
  localparam logic [15:0] cmd_rw_mask = `BT1CH_CMD_RW_MASK;

  ////////////////////////////////////////////////////////////////////////////

  logic [15:0] maker_identifier_q;
  logic [15:0] part_identifier_q;
  logic [15:0] command_q;
  logic sts_mdpe_q;
  logic sts_sta_q;
  logic sts_rta_q;
  logic sts_rma_q;
  logic sts_sse_q;
  logic sts_dpe_q;
  bt1ch_byte_t cache_line_size_q;
  bt1ch_byte_t primary_bus_number_q;
  bt1ch_byte_t secondary_bus_number_q;
  bt1ch_byte_t subordinate_bus_number_q;
  logic [3:0] io_base_q;
  logic [3:0] io_limit_q;
  logic cfg_ack_q;
  bt1ch_word_t cfg_rdata_q;
  logic wr;
  logic [15:0] io_bottom;
  logic [15:0] io_top;
  bt1ch_word_t rd_word;
  logic wr_cmd;
  logic wr_misc;
  logic wr_bus;
  logic wr_io;

  // Merges written bytes into a byte under its enable.
  function automatic bt1ch_byte_t bt1ch_merge(input bt1ch_byte_t old_v,
                                              input bt1ch_byte_t new_v,
                                              input logic en);
    bt1ch_merge = en ? new_v : old_v;
  endfunction : bt1ch_merge

  // A clearable flag: a fresh event wins over a clear in the same cycle.
  function automatic logic bt1ch_w1c(input logic cur,
                                     input logic set,
                                     input logic clr);
    bt1ch_w1c = set | (cur & ~clr);
  endfunction : bt1ch_w1c

  // True when a byte address falls in the dword of the given offset.
  function automatic logic bt1ch_dw_hit(input logic [7:0] addr,
                                        input bt1ch_byte_t ofs);
    bt1ch_dw_hit = (addr[7:2] == ofs[7:2]);
  endfunction : bt1ch_dw_hit

  assign wr = cfg_req & cfg_we;
  // The low two address bits pick a byte lane already carried by cfg_be,
  // so they are left out of every decode.
  assign wr_cmd = wr & bt1ch_dw_hit(cfg_addr, ofs_cmd_sts);
  assign wr_misc = wr & bt1ch_dw_hit(cfg_addr, ofs_misc);
  assign wr_bus = wr & bt1ch_dw_hit(cfg_addr, ofs_bus);
  assign wr_io = wr & bt1ch_dw_hit(cfg_addr, ofs_io);

  ////////////////////////////////////////////////////////////////////////////
  // Identity fields are never written by configuration software.
  // A load that falls in a reset cycle is lost; the defaults win.

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      maker_identifier_q <= `BT1CH_MAKER_ID_RST;
      part_identifier_q <= `BT1CH_PART_ID_RST;
    end
    else if (id_load)
    begin
      maker_identifier_q <= id_load_data[15:0];
      part_identifier_q <= id_load_data[31:16];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command register. Only implemented bits are stored, so the legacy bits
  // and the reserved top bits stay zero whatever is written.

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      command_q <= 16'h0000;
    else if (wr_cmd)
    begin
      if (cfg_be[0])
        command_q[7:0] <= cfg_wdata[7:0] & cmd_rw_mask[7:0];
      if (cfg_be[1])
        command_q[15:8] <= cfg_wdata[15:8] & cmd_rw_mask[15:8];
    end
  end

  assign io_space_en = command_q[`BT1CH_CMD_IO_EN];
  assign mem_space_en = command_q[`BT1CH_CMD_MEM_EN];
  assign bus_master_en = command_q[`BT1CH_CMD_BM_EN];
  assign parity_resp_en = command_q[`BT1CH_CMD_PERR_RESP];
  assign error_report_enable = command_q[`BT1CH_CMD_ERR_REP];

  ////////////////////////////////////////////////////////////////////////////
  // Side effects of the command bits on the datapath handshakes.

  assign up_forward = up_req_valid & bus_master_en;
  assign up_unsupported = up_req_valid & ~bus_master_en;
  assign up_ur_cpl = up_unsupported & up_req_nonposted;
  assign err_msg_send = err_detect & error_report_enable;
  assign own_intx_msg = own_intx_req
                        & ~command_q[`BT1CH_CMD_INTX_DIS];
  // Forwarded interrupts bypass the disable bit deliberately.
  assign fwd_intx_msg = fwd_intx_req;

  ////////////////////////////////////////////////////////////////////////////
  // Primary status flags.

  logic sts_wr;
  logic [15:0] sts_clr;
  logic mdpe_set;
  logic sse_set;

  // Enables gate the set side only; a flag already set stays readable
  // after software turns its enable off.
  assign mdpe_set = parity_err_evt & parity_resp_en;
  assign sse_set = err_msg_sent_evt & error_report_enable;
  assign sts_wr = wr_cmd;
  assign sts_clr = sts_wr ? {cfg_be[3] ? cfg_wdata[31:24] : 8'h00,
                             cfg_be[2] ? cfg_wdata[23:16] : 8'h00}
                          : 16'h0000;

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      sts_mdpe_q <= 1'b0;
      sts_sse_q <= 1'b0;
      sts_dpe_q <= 1'b0;
    end
    else
    begin
      sts_mdpe_q <= bt1ch_w1c(sts_mdpe_q, mdpe_set,
                              sts_clr[`BT1CH_STS_MDPE - 16]);
      sts_sse_q <= bt1ch_w1c(sts_sse_q, sse_set,
                             sts_clr[`BT1CH_STS_SSE - 16]);
      sts_dpe_q <= bt1ch_w1c(sts_dpe_q, poison_rcvd_evt,
                             sts_clr[`BT1CH_STS_DPE - 16]);
    end
  end

  // These three are read-only to software, so only reset clears them.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      sts_sta_q <= 1'b0;
      sts_rta_q <= 1'b0;
      sts_rma_q <= 1'b0;
    end
    else
    begin
      sts_sta_q <= sts_sta_q | ca_sent_evt;
      sts_rta_q <= sts_rta_q | ca_rcvd_evt;
      sts_rma_q <= sts_rma_q | ur_rcvd_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cache line size, bus numbers and the low I/O window.

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      cache_line_size_q <= `BT1CH_BYTE_RST;
    else if (wr_misc)
      cache_line_size_q <= bt1ch_merge(cache_line_size_q, cfg_wdata[7:0],
                                       cfg_be[0]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      primary_bus_number_q <= `BT1CH_BYTE_RST;
      secondary_bus_number_q <= `BT1CH_BYTE_RST;
      subordinate_bus_number_q <= `BT1CH_BYTE_RST;
    end
    else if (wr_bus)
    begin
      primary_bus_number_q <= bt1ch_merge(primary_bus_number_q,
                                          cfg_wdata[7:0], cfg_be[0]);
      secondary_bus_number_q <= bt1ch_merge(secondary_bus_number_q,
                                            cfg_wdata[15:8],
                                            cfg_be[1]);
      subordinate_bus_number_q <= bt1ch_merge(subordinate_bus_number_q,
                                              cfg_wdata[23:16],
                                              cfg_be[2]);
    end
  end

  assign primary_bus = primary_bus_number_q;
  assign secondary_bus = secondary_bus_number_q;
  assign subordinate_bus = subordinate_bus_number_q;

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      io_base_q <= `BT1CH_NIB_RST;
      io_limit_q <= `BT1CH_NIB_RST;
    end
    // Writes to the indicator nibbles are dropped; they are constants.
    else if (wr_io)
    begin
      if (cfg_be[0])
        io_base_q <= cfg_wdata[7:4];
      if (cfg_be[1])
        io_limit_q <= cfg_wdata[15:12];
    end
  end

  assign io_bottom = {io_base_q, `BT1CH_IO_LOW_ZERO};
  assign io_top = {io_limit_q, `BT1CH_IO_LOW_ONES};
  // A base above the limit makes an empty window, as software expects.
  assign io_in_window = (io_addr >= io_bottom)
                        && (io_addr <= io_top);
  assign io_primary_hit = io_in_window & io_space_en;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux. Offsets outside this block's range read zero.
  // Read data is registered only on reads, so writes never disturb it.

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (cfg_addr[7:2])
      ofs_id[7:2]:
        rd_word = {part_identifier_q, maker_identifier_q};
      ofs_cmd_sts[7:2]:
      begin
        rd_word[15:0] = command_q;
        rd_word[`BT1CH_STS_INT] = 1'b0;
        rd_word[`BT1CH_STS_CAP] = 1'b1;
        rd_word[`BT1CH_STS_MDPE] = sts_mdpe_q;
        rd_word[`BT1CH_STS_STA] = sts_sta_q;
        rd_word[`BT1CH_STS_RTA] = sts_rta_q;
        rd_word[`BT1CH_STS_RMA] = sts_rma_q;
        rd_word[`BT1CH_STS_SSE] = sts_sse_q;
        rd_word[`BT1CH_STS_DPE] = sts_dpe_q;
      end
      ofs_class[7:2]:
        rd_word = {`BT1CH_BASE_CLASS, `BT1CH_SUB_CLASS, `BT1CH_PROG_IF,
                   `BT1CH_REVISION};
      ofs_misc[7:2]:
        rd_word = {8'h00, `BT1CH_HDR_TYPE, `BT1CH_LAT_TIMER,
                   cache_line_size_q};
      ofs_bus[7:2]:
        rd_word = {`BT1CH_LAT_TIMER, subordinate_bus_number_q,
                   secondary_bus_number_q, primary_bus_number_q};
      ofs_io[7:2]:
        rd_word = {16'h0000, io_limit_q, `BT1CH_IO_32BIT, io_base_q,
                   `BT1CH_IO_32BIT};
      default:
        rd_word = 32'h0000_0000;
    endcase
  end

  // Every request, read or write, is answered one cycle later.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      cfg_ack_q <= 1'b0;
      cfg_rdata_q <= 32'h0000_0000;
    end
    else
    begin
      cfg_ack_q <= cfg_req;
      if (cfg_req && !cfg_we)
        cfg_rdata_q <= rd_word;
    end
  end

  assign cfg_ack = cfg_ack_q;
  assign cfg_rdata = cfg_rdata_q;

endmodule : bt1ch_regs

// *** verification/bt1ch_regs_assertions.sv ***
// Port-level checker for the bridge header register bank.
`timescale 1ns/1ps
module bt1ch_chk
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [7:0] cfg_addr,
  input wire bt1ch_pkg::bt1ch_be_t cfg_be,
  input wire bt1ch_pkg::bt1ch_word_t cfg_wdata,
  input wire logic cfg_ack,
  input wire bt1ch_pkg::bt1ch_word_t cfg_rdata,
  input wire logic err_detect,
  input wire logic err_msg_send,
  input wire logic error_report_enable,
  input wire logic fwd_intx_req,
  input wire logic fwd_intx_msg,
  input wire logic up_req_valid,
  input wire logic up_req_nonposted,
  input wire logic up_forward,
  input wire logic up_unsupported,
  input wire logic up_ur_cpl,
  input wire logic io_space_en,
  input wire logic mem_space_en,
  input wire logic bus_master_en,
  input wire logic io_in_window,
  input wire logic io_primary_hit,
  input wire bt1ch_pkg::bt1ch_byte_t primary_bus
);
  import bt1ch_pkg::*;
  logic rd_sts_q;
  logic rd_cls_q;
  logic rd_misc_q;
  bt1ch_byte_t wbyte_q;
  // Gating with nrst keeps a read issued during reset from being judged.
  always_ff @(posedge ref_clk)
  begin
    rd_sts_q <= nrst && cfg_req && !cfg_we && cfg_addr[7:2] == 6'h01;
    rd_cls_q <= nrst && cfg_req && !cfg_we && cfg_addr[7:2] == 6'h02;
    rd_misc_q <= nrst && cfg_req && !cfg_we && cfg_addr[7:2] == 6'h03;
    wbyte_q <= cfg_wdata[7:0];
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////////////////////////////
  cmd_reset_a : assert property (
    $rose(nrst) |-> !io_space_en && !mem_space_en && !bus_master_en
      && !error_report_enable) else $error("command not cleared by reset");
  cap_flag_a : assert property (
    rd_sts_q |-> cfg_ack && cfg_rdata[20] && !cfg_rdata[19])
    else $error("status fixed bits wrong");
  class_code_a : assert property (
    rd_cls_q |-> cfg_rdata[31:8] == 24'h060400) else $error("class wrong");
  hdr_type_a : assert property (
    rd_misc_q |-> cfg_rdata[31:8] == 24'h000100) else $error("header wrong");
  bus_write_a : assert property (
    cfg_req && cfg_we && cfg_addr[7:2] == 6'h06 && cfg_be[0]
      |=> primary_bus == wbyte_q)
    else $error("primary bus not written");
  err_gate_a : assert property (
    err_msg_send == (err_detect && error_report_enable))
    else $error("error message gating wrong");
  fwd_intx_a : assert property (
    fwd_intx_msg == fwd_intx_req) else $error("forwarded interrupt altered");
  upstream_ur_a : assert property (
    up_req_valid |-> up_forward == bus_master_en
      && up_unsupported != bus_master_en
      && up_ur_cpl == (!bus_master_en && up_req_nonposted))
    else $error("upstream decision wrong");
  io_hit_a : assert property (
    io_primary_hit == (io_in_window && io_space_en))
    else $error("io hit wrong");
  cover property (rd_sts_q && cfg_rdata[31]);
  cover property (up_req_valid && up_ur_cpl);
  cover property (io_in_window && io_primary_hit);
endmodule : bt1ch_chk

bind bt1ch_regs bt1ch_chk u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .cfg_req(cfg_req), .cfg_we(cfg_we),
  .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
  .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .err_detect(err_detect),
  .err_msg_send(err_msg_send), .error_report_enable(error_report_enable),
  .fwd_intx_req(fwd_intx_req), .fwd_intx_msg(fwd_intx_msg),
  .up_req_valid(up_req_valid), .up_req_nonposted(up_req_nonposted),
  .up_forward(up_forward), .up_unsupported(up_unsupported),
  .up_ur_cpl(up_ur_cpl), .io_space_en(io_space_en),
  .mem_space_en(mem_space_en), .bus_master_en(bus_master_en),
  .io_in_window(io_in_window), .io_primary_hit(io_primary_hit),
  .primary_bus(primary_bus)
);

// *** verification/bt1ch_rc_model.sv ***
// Root complex model that issues configuration reads and writes.
`timescale 1ns/1ps
module bt1ch_rc
(
  input wire logic ref_clk,
  output logic cfg_req,
  output logic cfg_we,
  output logic [7:0] cfg_addr,
  output bt1ch_pkg::bt1ch_be_t cfg_be,
  output bt1ch_pkg::bt1ch_word_t cfg_wdata,
  input wire logic cfg_ack,
  input wire bt1ch_pkg::bt1ch_word_t cfg_rdata
);
  import bt1ch_pkg::*;
  initial
  begin
    cfg_req = 1'h0;
    cfg_we = 1'h0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
  end
  // Released address and write data lines carry the inverse so a stale value cannot pass as valid.
  task automatic xfer(input logic we, input logic [7:0] a, input bt1ch_be_t be,
                      input bt1ch_word_t wd, output bt1ch_word_t rd,
                      output logic ok);
    @(negedge ref_clk);
    cfg_req = 1'h1;
    cfg_we = we;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = wd;
    @(negedge ref_clk);
    ok = cfg_ack;
    rd = cfg_rdata;
    cfg_req = 1'h0;
    cfg_addr = ~a;
    cfg_wdata = ~wd;
  endtask : xfer
endmodule : bt1ch_rc

// *** verification/bt1ch_regs_tb.sv ***
// Self-checking bench for the bridge header register bank.
`timescale 1ns/1ps
module bt1ch_regs_tb;
  import bt1ch_pkg::*;
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic id_load = 1'h0;
  bt1ch_word_t id_load_data = 32'h0;
  logic [5:0] ev = 6'h00;
  logic err_detect = 1'h0;
  logic own_intx_req = 1'h0;
  logic fwd_intx_req = 1'h0;
  logic up_req_valid = 1'h0;
  logic up_req_nonposted = 1'h0;
  logic [15:0] io_addr = 16'h0000;
  logic cfg_req, cfg_we, cfg_ack;
  logic [7:0] cfg_addr;
  bt1ch_be_t cfg_be;
  bt1ch_word_t cfg_wdata, cfg_rdata;
  logic io_space_en, mem_space_en, bus_master_en, parity_resp_en;
  logic error_report_enable, err_msg_send, own_intx_msg, fwd_intx_msg;
  logic up_forward, up_unsupported, up_ur_cpl, io_in_window, io_primary_hit;
  logic [10:0] ctl;
  bt1ch_byte_t pri_bus, sec_bus, sub_bus;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [7:0] adr [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h1c};
  bt1ch_word_t rst_val [7] = '{32'h3c4d1a2b, 32'h00100000, 32'h06040001,
    32'h00010000, 32'h0, 32'h0, 32'h00000101};
  logic [15:0] ioa [4] = '{16'h2fff, 16'h3000, 16'h5fff, 16'h6000};
  logic iow [4] = '{1'h0, 1'h1, 1'h1, 1'h0};
  assign ctl = {io_space_en, mem_space_en, bus_master_en, parity_resp_en,
    error_report_enable, err_msg_send, own_intx_msg, fwd_intx_msg,
    up_forward, up_unsupported, up_ur_cpl};
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end
  bt1ch_rc u_rc (.ref_clk, .cfg_req, .cfg_we, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_ack, .cfg_rdata);
  bt1ch_regs u_dut (.ref_clk, .nrst, .cfg_req, .cfg_we, .cfg_addr, .cfg_be,
    .cfg_wdata, .cfg_ack, .cfg_rdata, .id_load, .id_load_data,
    .parity_err_evt(ev[5]), .ca_sent_evt(ev[4]), .ca_rcvd_evt(ev[3]),
    .ur_rcvd_evt(ev[2]), .err_msg_sent_evt(ev[1]), .poison_rcvd_evt(ev[0]),
    .err_detect, .err_msg_send, .own_intx_req, .fwd_intx_req, .own_intx_msg,
    .fwd_intx_msg, .up_req_valid, .up_req_nonposted, .up_forward,
    .up_unsupported, .up_ur_cpl, .io_space_en, .mem_space_en, .bus_master_en,
    .parity_resp_en, .error_report_enable, .primary_bus(pri_bus),
    .secondary_bus(sec_bus), .subordinate_bus(sub_bus), .io_addr,
    .io_in_window,
    .io_primary_hit);
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input bt1ch_word_t got, input bt1ch_word_t exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input bt1ch_word_t exp);
    bt1ch_word_t d;
    logic ok;
    u_rc.xfer(1'h0, a, 4'hf, 32'h0, d, ok);
    chk({31'h0, ok}, 32'h1);
    chk(d, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input bt1ch_be_t be, bt1ch_word_t v);
    bt1ch_word_t d;
    logic ok;
    u_rc.xfer(1'h1, a, be, v, d, ok);
    chk({31'h0, ok}, 32'h1);
  endtask : wr
  task automatic pulse(input logic [5:0] m);
    @(negedge ref_clk);
    ev = m;
    @(negedge ref_clk);
    ev = 6'h00;
  endtask : pulse
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // The whole run is under a hundred cycles; the ceiling leaves wide margin.
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(negedge ref_clk);
    nrst = 1'h1;
    for (int i = 0; i < 7; i++)
      rd(adr[i], rst_val[i]);
    wr(8'h00, 4'hf, 32'hffffffff);
    rd(8'h00, 32'h3c4d1a2b);
    @(negedge ref_clk);
    id_load = 1'h1;
    id_load_data = 32'h55667788;
    @(negedge ref_clk);
    id_load = 1'h0;
    rd(8'h00, 32'h55667788);
    wr(8'h04, 4'h3, 32'hffffffff);
    rd(8'h04, 32'h00100547);
    wr(8'h0c, 4'hf, 32'hffffffff);
    rd(8'h0c, 32'h000100ff);
    wr(8'h18, 4'hf, 32'hffffffff);
    rd(8'h18, 32'h00ffffff);
    chk({8'h00, sub_bus, sec_bus, pri_bus}, 32'h00ffffff);
    wr(8'h1c, 4'hf, 32'hffffffff);
    rd(8'h1c, 32'h0000f1f1);
    wr(8'h1c, 4'h3, 32'h00005131);
    for (int i = 0; i < 4; i++)
    begin
      @(negedge ref_clk);
      io_addr = ioa[i];
      #1;
      chk({30'h0, io_in_window, io_primary_hit},
        {30'h0, iow[i], iow[i]});
    end
    @(negedge ref_clk);
    err_detect = 1'h1;
    own_intx_req = 1'h1;
    fwd_intx_req = 1'h1;
    up_req_valid = 1'h1;
    up_req_nonposted = 1'h1;
    #1;
    chk({21'h0, ctl}, 32'h000007ec);
    wr(8'h04, 4'h3, 32'h0);
    chk({21'h0, ctl}, 32'h0000001b);
    pulse(6'h3f);
    rd(8'h04, 32'hb8100000);
    wr(8'h04, 4'h3, 32'h00000140);
    pulse(6'h22);
    rd(8'h04, 32'hf9100140);
    wr(8'h04, 4'hc, 32'h0);
    rd(8'h04, 32'hf9100140);
    wr(8'h04, 4'hc, 32'hffffffff);
    rd(8'h04, 32'h38100140);
    // A parity event in the cycle of its clear must leave the flag set.
    fork
      pulse(6'h20);
      wr(8'h04, 4'hc, 32'hffffffff);
    join
    rd(8'h04, 32'h39100140);
    @(negedge ref_clk);
    nrst = 1'h0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'h1;
    rd(8'h04, 32'h00100000);
    rd(8'h18, 32'h0);
    chk({8'h00, sub_bus, sec_bus, pri_bus}, 32'h0);
    tally_and_finish();
  end
endmodule : bt1ch_regs_tb
